// ### testbench/core_model.sv
`timescale 1ns/1ps
module core_model (
  input  logic clock_i,
  input  logic rst_i,
  input  logic hold_i,
  input  logic reset_req_i,
  output logic cycle_start_o,
  output logic insn_done_o,
  output logic hard_ack_o,
  output logic reset_ack_o
);
  logic [1:0] phase;
  logic [2:0] wait_cnt;
  // ---------------------------------------------------------------
  // Four-cycle instruction rhythm, late acknowledges
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= '0;
      wait_cnt <= '0;
      cycle_start_o <= '0;
      insn_done_o <= '0;
      hard_ack_o <= '0;
      reset_ack_o <= '0;
    end else begin
      phase <= phase + 2'h1;
      cycle_start_o <= (phase == 2'h3);
      insn_done_o <= (phase == 2'h1) && !hold_i;
      wait_cnt <= hold_i ? wait_cnt + 3'h1 : 3'h0;
      hard_ack_o <= hold_i && !reset_req_i && (wait_cnt == 3'h5);
      reset_ack_o <= reset_req_i && (wait_cnt == 3'h2);
    end
  end
endmodule

// ### testbench/test_trap_and_interrupt_sequencer.sv
`timescale 1ns/1ps
module test_trap_and_interrupt_sequencer;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clock_i = 0, rst_i = 1, watchdog_timeout_i = 0, brownout_reset_i = 0, osc_fail_i = 0;
  logic w_write_i = 0, ptr_use_i = 0, illegal_fetch_i = 0, flush_i = 0, sp_load_i = 0, level_write_i = 0;
  logic nesting_disable_bit_i = 0, alternate_table_select_i = 0, return_from_interrupt_op_i = 0;
  logic popped_top_bit_i = 0, shadow_push_i = 0, shadow_pop_i = 0;
  logic [3:0] w_write_idx_i = '0, ptr_idx_i = '0;
  logic [2:0] level_wdata_i = '0;
  logic [7:0] popped_status_byte_i = '0, status_low_byte_o;
  logic [4:0] status_flags_i = 5'h15;
  logic [15:0] sp_value_i = '0, stack_limit_register_i = 16'hFFFF, rcause_clear_i = '0, reset_cause_register_o;
  logic [23:0] pc_i = 24'h000ABC, vector_addr_o, stack_pc_o;
  logic [53:0] interrupt_flag_registers_i = '0, interrupt_enable_registers_i = '1;
  exc_pkg::prio_array_t irq_prio_i = '0;
  exc_pkg::math_ev_t math_ev_i = '0;
  exc_pkg::math_ctl_t math_ctl_i = '0;
  exc_pkg::addr_ev_t addr_ev_i = '0;
  exc_pkg::shadow_t shadow_save_i = '0, shadow_restore_o;
  logic cycle_start_i, insn_done_i, hard_trap_ack_i, reset_ack_i, entry_o, stack_top_bit_o, hold_exec_o;
  logic reset_req_o, shadow_full_o, shadow_overrun_o;
  logic [3:0] cpu_priority_level_o;
  logic [5:0] vector_num_o;
  int miscompares = 0, n_compared = 0, cyc = 0, n_entry = 0;

  trap_and_interrupt_sequencer i_trap_and_interrupt_sequencer (.*);
  core_model i_core_model (.clock_i(clock_i), .rst_i(rst_i), .hold_i(hold_exec_o), .reset_req_i(reset_req_o),
    .cycle_start_o(cycle_start_i), .insn_done_o(insn_done_i), .hard_ack_o(hard_trap_ack_i),
    .reset_ack_o(reset_ack_i));

  // ---------------------------------------------------------------
  // Clock, entry count and hang limit
  // ---------------------------------------------------------------
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    n_entry += (entry_o === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [23:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic waitfor(ref logic s, input logic v);
    repeat (60) begin
      @(posedge clock_i);
      #1;
      if (s === v) break;
    end
    chk("wait", s, v);
  endtask
  task entry(input logic [5:0] v, input logic [3:0] l);
    waitfor(entry_o, 1'b1);
    chk("vector", vector_num_o, v);
    chk("level", cpu_priority_level_o, l);
  endtask
  task ret(input logic [7:0] sb);
    tick(1);
    popped_status_byte_i <= sb;
    return_from_interrupt_op_i <= 1;
    tick(1);
    return_from_interrupt_op_i <= 0;
    #1 chk("ret level", cpu_priority_level_o, {popped_top_bit_i, sb[7:5]});
  endtask
  task rst_exp(input int b);
    waitfor(reset_req_o, 1'b1);
    chk("cause", reset_cause_register_o, 16'h0001 << b);
    waitfor(reset_req_o, 1'b0);
    tick(1);
    rcause_clear_i <= '1;
    tick(1);
    rcause_clear_i <= '0;
  endtask
  task test_done;
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(10);
    rst_i <= 0;
    irq_prio_i[3] <= 3'h3;
    interrupt_flag_registers_i[3] <= 1;
    entry(6'h0B, 4'h3);
    chk("addr", vector_addr_o, 24'h00001A);
    chk("pc", stack_pc_o, 24'h000ABC);
    chk("status byte", status_low_byte_o, 8'h15);
    interrupt_flag_registers_i[3] <= 0;
    ret(8'h00);
    tick(1);
    alternate_table_select_i <= 1;
    irq_prio_i[0] <= 3'h5;
    irq_prio_i[2] <= 3'h5;
    interrupt_flag_registers_i[2:0] <= 3'h5;
    entry(6'h08, 4'h5);
    chk("alt addr", vector_addr_o, 24'h000094);
    tick(1);
    interrupt_flag_registers_i[0] <= 0;
    nesting_disable_bit_i <= 1;
    irq_prio_i[2] <= 3'h7;
    tick(20);
    chk("nest", n_entry, 2);
    nesting_disable_bit_i <= 0;
    entry(6'h0A, 4'h7);
    interrupt_flag_registers_i[2] <= 0;
    alternate_table_select_i <= 0;
    ret(8'hA0);
    ret(8'h00);
    tick(1);
    level_write_i <= 1;
    level_wdata_i <= 3'h7;
    interrupt_flag_registers_i[5] <= 1;
    irq_prio_i[5] <= 3'h7;
    tick(1);
    level_write_i <= 0;
    tick(20);
    chk("masked", n_entry, 3);
    math_ev_i.div_zero <= 1;
    tick(1);
    math_ev_i <= '0;
    entry(6'h03, 4'hB);
    interrupt_flag_registers_i[5] <= 0;
    ret(8'hE0);
    tick(1);
    addr_ev_i.misaligned <= 1;
    tick(1);
    addr_ev_i <= '0;
    entry(6'h04, 4'hC);
    chk("hold", hold_exec_o, 1'b1);
    waitfor(hold_exec_o, 1'b0);
    tick(1);
    sp_load_i <= 1;
    sp_value_i <= 16'h07FE;
    tick(1);
    sp_load_i <= 0;
    entry(6'h05, 4'hD);
    chk("top bit", stack_top_bit_o, 1'b1);
    chk("nested status byte", status_low_byte_o, 8'h95);
    waitfor(hold_exec_o, 1'b0);
    popped_top_bit_i <= 1;
    ret(8'h80);
    popped_top_bit_i <= 0;
    ret(8'h00);
    tick(1);
    osc_fail_i <= 1;
    entry(6'h06, 4'hE);
    tick(1);
    addr_ev_i.misaligned <= 1;
    tick(1);
    addr_ev_i <= '0;
    rst_exp(15);
    addr_ev_i.misaligned <= 1;
    math_ev_i.div_zero <= 1;
    tick(1);
    addr_ev_i <= '0;
    math_ev_i <= '0;
    rst_exp(4);
    watchdog_timeout_i <= 1;
    tick(1);
    watchdog_timeout_i <= 0;
    rst_exp(0);
    brownout_reset_i <= 1;
    tick(3);
    brownout_reset_i <= 0;
    rst_exp(3);
    w_write_i <= 1;
    w_write_idx_i <= 4'h4;
    ptr_idx_i <= 4'h4;
    tick(1);
    w_write_i <= 0;
    ptr_use_i <= 1;
    tick(1);
    ptr_use_i <= 0;
    tick(8);
    chk("written ptr", reset_cause_register_o, '0);
    ptr_use_i <= 1;
    ptr_idx_i <= 4'h2;
    tick(1);
    ptr_use_i <= 0;
    rst_exp(1);
    @(posedge clock_i iff cycle_start_i);
    tick(2);
    illegal_fetch_i <= 1;
    tick(1);
    illegal_fetch_i <= 0;
    flush_i <= 1;
    tick(1);
    flush_i <= 0;
    tick(10);
    chk("flushed", reset_cause_register_o, '0);
    illegal_fetch_i <= 1;
    tick(1);
    illegal_fetch_i <= 0;
    rst_exp(2);
    shadow_save_i <= '{dc: 1, n: 0, ov: 1, z: 0, c: 1, w: 64'h0123_4567_89AB_CDEF};
    shadow_push_i <= 1;
    tick(2);
    shadow_push_i <= 0;
    #1 chk("overrun", shadow_overrun_o, 1'b1);
    chk("restore", shadow_restore_o[23:0], 24'hABCDEF);
    tick(1);
    shadow_pop_i <= 1;
    tick(1);
    shadow_pop_i <= 0;
    #1 chk("full", shadow_full_o, 1'b0);
    math_ctl_i.ovf_a_en <= 1;
    math_ctl_i.guard_a_used <= 1;
    math_ev_i.ovf31_a <= 1;
    tick(1);
    math_ev_i <= '0;
    tick(8);
    chk("guarded", n_entry, 7);
    math_ctl_i.guard_a_used <= 0;
    math_ev_i.ovf31_a <= 1;
    tick(1);
    math_ev_i <= '0;
    entry(6'h03, 4'hB);
    test_done;
  end
endmodule

// ### verilog/exc_pkg.sv
package exc_pkg;

  // ---------------------------------------------------------------
  // Sizes and levels
  // ---------------------------------------------------------------
  localparam int          NUM_IRQ      = 54;
  localparam logic [3:0]  LVL_TRAP_MIN = 4'h8;
  localparam logic [3:0]  LVL_MATH     = 4'hB;
  localparam logic [3:0]  LVL_ADDR     = 4'hC;
  localparam logic [3:0]  LVL_STACK    = 4'hD;
  localparam logic [3:0]  LVL_OSC      = 4'hE;
  localparam logic [3:0]  LVL_MASK_ALL = 4'h7;
  localparam logic [3:0]  LEVEL_RESET  = 4'h0;
  localparam logic [5:0]  VEC_IRQ_BASE = 6'h08;

  // ---------------------------------------------------------------
  // Vector tables and stack floor
  // ---------------------------------------------------------------
  localparam logic [23:0] TABLE_BASE   = 24'h000004;
  localparam logic [23:0] TABLE_SPAN   = 24'h000080;
  localparam logic [15:0] STACK_FLOOR  = 16'h0800;

  // ---------------------------------------------------------------
  // Reset cause bit positions
  // ---------------------------------------------------------------
  localparam int          RC_WDT       = 0;
  localparam int          RC_UNINIT    = 1;
  localparam int          RC_ILLEGAL   = 2;
  localparam int          RC_BROWNOUT  = 3;
  localparam int          RC_LOCKOUT   = 4;
  localparam int          RC_CONFLICT  = 15;
  localparam logic [15:0] RCAUSE_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN       = 2'b00,
    ST_HARD_WAIT = 2'b01,
    ST_RESET     = 2'b11
  } seq_state_t;

  typedef logic [NUM_IRQ-1:0][2:0] prio_array_t;

  typedef struct packed {
    logic div_zero;
    logic shift_over;
    logic ovf31_a;
    logic ovf31_b;
    logic ovf39_a;
    logic ovf39_b;
  } math_ev_t;

  typedef struct packed {
    logic ovf_a_en;
    logic ovf_b_en;
    logic cat_en;
    logic guard_a_used;
    logic guard_b_used;
    logic sat_off;
  } math_ctl_t;

  typedef struct packed {
    logic misaligned;
    logic unimpl_data;
    logic unimpl_prog;
    logic vector_fetch;
    logic branch_unimpl;
    logic pc_unimpl;
  } addr_ev_t;

  typedef struct packed {
    logic             dc;
    logic             n;
    logic             ov;
    logic             z;
    logic             c;
    logic [3:0][15:0] w;
  } shadow_t;

endpackage

// ### verilog/shadow_store.sv
`timescale 1ns/1ps
module shadow_store (
  input  logic            clock_i,
  input  logic            rst_i,
  input  logic            push_i,
  input  logic            pop_i,
  input  exc_pkg::shadow_t save_i,
  output exc_pkg::shadow_t restore_o,
  output logic            full_o,
  output logic            overrun_o
);

  exc_pkg::shadow_t store;
  exc_pkg::shadow_t next_store;
  logic             full;
  logic             next_full;
  logic             overrun;
  logic             next_overrun;

  // Single-level store, overrun flags a nested push
  always_comb begin
    next_store   = push_i ? save_i : store;
    next_full    = push_i | (full & ~pop_i);
    next_overrun = push_i & full & ~pop_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      store   <= '0;
      full    <= 1'b0;
      overrun <= 1'b0;
    end else begin
      store   <= next_store;
      full    <= next_full;
      overrun <= next_overrun;
    end
  end

  assign restore_o = store;
  assign full_o    = full;
  assign overrun_o = overrun;

  property p_nested_push;
    @(posedge clock_i) disable iff (rst_i)
    push_i && full && !pop_i |=> overrun_o && restore_o == $past(save_i);
  endproperty
  a_nested_push: assert property (p_nested_push) else $error("nested shadow push not flagged");

endmodule

// ### verilog/trap_and_interrupt_sequencer.sv
`timescale 1ns/1ps
module trap_and_interrupt_sequencer (
  input  logic                 clock_i,
  input  logic                 rst_i,
  input  logic                 cycle_start_i,
  input  logic                 insn_done_i,
  input  logic                 watchdog_timeout_i,
  input  logic                 brownout_reset_i,
  input  logic                 osc_fail_i,
  input  logic                 w_write_i,
  input  logic [3:0]           w_write_idx_i,
  input  logic                 ptr_use_i,
  input  logic [3:0]           ptr_idx_i,
  input  logic                 illegal_fetch_i,
  input  logic                 flush_i,
  input  exc_pkg::math_ev_t    math_ev_i,
  input  exc_pkg::math_ctl_t   math_ctl_i,
  input  exc_pkg::addr_ev_t    addr_ev_i,
  input  logic                 sp_load_i,
  input  logic [15:0]          sp_value_i,
  input  logic [15:0]          stack_limit_register_i,
  input  logic [exc_pkg::NUM_IRQ-1:0] interrupt_flag_registers_i,
  input  logic [exc_pkg::NUM_IRQ-1:0] interrupt_enable_registers_i,
  input  exc_pkg::prio_array_t irq_prio_i,
  input  logic                 nesting_disable_bit_i,
  input  logic                 alternate_table_select_i,
  input  logic                 level_write_i,
  input  logic [2:0]           level_wdata_i,
  input  logic [23:0]          pc_i,
  input  logic [4:0]           status_flags_i,
  input  logic                 return_from_interrupt_op_i,
  input  logic [7:0]           popped_status_byte_i,
  input  logic                 popped_top_bit_i,
  input  logic                 hard_trap_ack_i,
  input  logic                 reset_ack_i,
  input  logic [15:0]          rcause_clear_i,
  input  logic                 shadow_push_i,
  input  logic                 shadow_pop_i,
  input  exc_pkg::shadow_t     shadow_save_i,
  output logic [3:0]           cpu_priority_level_o,
  output logic                 entry_o,
  output logic [5:0]           vector_num_o,
  output logic [23:0]          vector_addr_o,
  output logic [23:0]          stack_pc_o,
  output logic [7:0]           status_low_byte_o,
  output logic                 stack_top_bit_o,
  output logic                 hold_exec_o,
  output logic                 reset_req_o,
  output logic [15:0]          reset_cause_register_o,
  output exc_pkg::shadow_t     shadow_restore_o,
  output logic                 shadow_full_o,
  output logic                 shadow_overrun_o
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic brown_s1, brown_s2, osc_s1, osc_s2, osc_d;

  // Brown-out and oscillator monitor come from outside the clock domain
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      brown_s1 <= 1'b0;
      brown_s2 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_d  <= 1'b0;
    end else begin
      brown_s1 <= brownout_reset_i;
      brown_s2 <= brown_s1;
      osc_s1 <= osc_fail_i;
      osc_s2 <= osc_s1;
      osc_d  <= osc_s2;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  exc_pkg::seq_state_t state, next_state;
  logic [3:0]  cpl, next_cpl, wait_lvl, next_wait_lvl;
  logic [3:0]  pend, next_pend, in_service, next_in_service;
  logic [15:0] w_written, next_w_written, rcause, next_rcause;
  logic [exc_pkg::NUM_IRQ-1:0] req, next_req;
  logic        illegal_held, next_illegal_held;
  logic        entry, next_entry, hold, next_hold, rst_req, next_rst_req;
  logic [5:0]  vec, next_vec;
  logic [23:0] vaddr, next_vaddr, spc, next_spc;
  logic [7:0]  sbyte, next_sbyte;
  logic        sipl3, next_sipl3;

  // ---------------------------------------------------------------
  // Request sampling and arbitration
  // ---------------------------------------------------------------
  logic [exc_pkg::NUM_IRQ-1:0] live;
  genvar gi;
  generate
    for (gi = 0; gi < exc_pkg::NUM_IRQ; gi++) begin : g_req
      // Flag with enable set and nonzero priority is a request
      assign live[gi] = interrupt_flag_registers_i[gi] & interrupt_enable_registers_i[gi]
                        & (irq_prio_i[gi] != 3'h0);
    end
  endgenerate

  logic [2:0] irq_prio;
  logic [5:0] irq_idx;

  // Highest priority wins, descending scan lets lower numbers win ties
  always_comb begin
    irq_prio = 3'h0;
    irq_idx  = 6'h00;
    for (int i = exc_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i] && irq_prio_i[i] >= irq_prio) begin
        irq_prio = irq_prio_i[i];
        irq_idx  = 6'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Trap and reset detection
  // ---------------------------------------------------------------
  logic       math_hit, stack_hit, uninit_hit, illegal_hit, multi, conflict, fatal;
  logic [3:0] new_trap, trap_lvl;

  always_comb begin
    math_hit = math_ev_i.div_zero | math_ev_i.shift_over
             | (math_ctl_i.ovf_a_en & math_ev_i.ovf31_a & ~math_ctl_i.guard_a_used)
             | (math_ctl_i.ovf_b_en & math_ev_i.ovf31_b & ~math_ctl_i.guard_b_used)
             | (math_ctl_i.cat_en & math_ctl_i.sat_off & (math_ev_i.ovf39_a | math_ev_i.ovf39_b));
    stack_hit = sp_load_i & ((sp_value_i > stack_limit_register_i)
                | (sp_value_i < exc_pkg::STACK_FLOOR));
    // Index 0 math, 1 address, 2 stack, 3 oscillator
    new_trap = {osc_s2 & ~osc_d, stack_hit, |addr_ev_i, math_hit};
    trap_lvl = pend[3] ? exc_pkg::LVL_OSC :
               pend[2] ? exc_pkg::LVL_STACK :
               pend[1] ? exc_pkg::LVL_ADDR :
               pend[0] ? exc_pkg::LVL_MATH : 4'h0;
    multi    = $countones(new_trap) > 1;
    conflict = 1'b0;
    for (int j = 1; j < 4; j++) begin
      if (new_trap[j] && (trap_lvl > 4'(exc_pkg::LVL_MATH + 4'(j))
          || (state == exc_pkg::ST_HARD_WAIT && wait_lvl > 4'(exc_pkg::LVL_MATH + 4'(j)))
          || (cpl[3] && cpl > 4'(exc_pkg::LVL_MATH + 4'(j))))) begin
        conflict = 1'b1;
      end
    end
    uninit_hit  = ptr_use_i & ~w_written[ptr_idx_i];
    illegal_hit = insn_done_i & illegal_held & ~flush_i;
    fatal = watchdog_timeout_i | uninit_hit | illegal_hit | brown_s2 | multi | conflict;
  end

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  logic take_trap, take_irq;

  always_comb begin
    next_state        = state;
    next_cpl          = cpl;
    next_wait_lvl     = wait_lvl;
    next_pend         = pend;
    next_in_service   = in_service;
    next_w_written    = w_written;
    next_rcause       = rcause & ~rcause_clear_i;
    next_req          = cycle_start_i ? live : req;
    next_illegal_held = (illegal_held & ~flush_i & ~insn_done_i) | illegal_fetch_i;
    next_entry        = 1'b0;
    next_hold         = hold;
    next_rst_req      = rst_req;
    next_vec          = vec;
    next_vaddr        = vaddr;
    next_spc          = spc;
    next_sbyte        = sbyte;
    next_sipl3        = sipl3;
    if (w_write_i) begin
      next_w_written[w_write_idx_i] = 1'b1;
    end
    // Traps complete their instruction before entry
    take_trap = state == exc_pkg::ST_RUN && insn_done_i && !fatal
                && !return_from_interrupt_op_i && trap_lvl > cpl;
    take_irq  = state == exc_pkg::ST_RUN && insn_done_i && !fatal && !take_trap
                && !return_from_interrupt_op_i && {1'b0, irq_prio} > cpl
                && !(nesting_disable_bit_i && in_service != 4'h0);
    if (level_write_i && !nesting_disable_bit_i) begin
      next_cpl[2:0] = level_wdata_i;
    end
    if (return_from_interrupt_op_i && state == exc_pkg::ST_RUN) begin
      next_cpl = {popped_top_bit_i, popped_status_byte_i[7:5]};
      if (in_service != 4'h0) begin
        next_in_service = in_service - 4'h1;
      end
    end
    if (take_trap || take_irq) begin
      next_entry = 1'b1;
      next_spc   = pc_i;
      next_sbyte = {cpl[2:0], status_flags_i};
      next_sipl3 = cpl[3];
      next_vec   = take_trap ? 6'(trap_lvl - exc_pkg::LVL_TRAP_MIN) : irq_idx + exc_pkg::VEC_IRQ_BASE;
      next_cpl   = take_trap ? trap_lvl : {1'b0, irq_prio};
      next_vaddr = (alternate_table_select_i ? exc_pkg::TABLE_BASE + exc_pkg::TABLE_SPAN
                    : exc_pkg::TABLE_BASE) + {17'h00000, next_vec, 1'b0};
      if (in_service != 4'hF) begin
        next_in_service = in_service + 4'h1;
      end
    end
    // Entry clears the serviced trap, a fresh event still sets it
    if (take_trap) begin
      next_pend[trap_lvl[1:0] - 2'h3] = 1'b0;
      if (trap_lvl >= exc_pkg::LVL_ADDR) begin
        next_state    = exc_pkg::ST_HARD_WAIT;
        next_wait_lvl = trap_lvl;
        next_hold     = 1'b1;
      end
    end
    if (state == exc_pkg::ST_HARD_WAIT && hard_trap_ack_i) begin
      next_state = exc_pkg::ST_RUN;
      next_hold  = 1'b0;
    end
    if (state == exc_pkg::ST_RESET && reset_ack_i) begin
      next_state        = exc_pkg::ST_RUN;
      next_rst_req      = 1'b0;
      next_hold         = 1'b0;
      next_cpl          = exc_pkg::LEVEL_RESET;
      next_pend         = 4'h0;
      next_in_service   = 4'h0;
      next_w_written    = 16'h0000;
      next_illegal_held = 1'b0;
    end
    // A fresh trap event survives both entry and reset release
    next_pend = next_pend | new_trap;
    // Any reset source wins over the state, hold and reset request set above
    if (fatal) begin
      next_state   = exc_pkg::ST_RESET;
      next_rst_req = 1'b1;
      next_hold    = 1'b1;
      next_rcause[exc_pkg::RC_WDT]      = next_rcause[exc_pkg::RC_WDT] | watchdog_timeout_i;
      next_rcause[exc_pkg::RC_UNINIT]   = next_rcause[exc_pkg::RC_UNINIT] | uninit_hit;
      next_rcause[exc_pkg::RC_ILLEGAL]  = next_rcause[exc_pkg::RC_ILLEGAL] | illegal_hit;
      next_rcause[exc_pkg::RC_BROWNOUT] = next_rcause[exc_pkg::RC_BROWNOUT] | brown_s2;
      next_rcause[exc_pkg::RC_LOCKOUT]  = next_rcause[exc_pkg::RC_LOCKOUT] | multi;
      next_rcause[exc_pkg::RC_CONFLICT] = next_rcause[exc_pkg::RC_CONFLICT] | conflict;
    end
  end

  // Registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state        <= exc_pkg::ST_RUN;
      cpl          <= exc_pkg::LEVEL_RESET;
      wait_lvl     <= 4'h0;
      pend         <= 4'h0;
      in_service   <= 4'h0;
      w_written    <= 16'h0000;
      rcause       <= exc_pkg::RCAUSE_RESET;
      req          <= '0;
      illegal_held <= 1'b0;
      entry        <= 1'b0;
      hold         <= 1'b0;
      rst_req      <= 1'b0;
      vec          <= 6'h00;
      vaddr        <= 24'h000000;
      spc          <= 24'h000000;
      sbyte        <= 8'h00;
      sipl3        <= 1'b0;
    end else begin
      state        <= next_state;
      cpl          <= next_cpl;
      wait_lvl     <= next_wait_lvl;
      pend         <= next_pend;
      in_service   <= next_in_service;
      w_written    <= next_w_written;
      rcause       <= next_rcause;
      req          <= next_req;
      illegal_held <= next_illegal_held;
      entry        <= next_entry;
      hold         <= next_hold;
      rst_req      <= next_rst_req;
      vec          <= next_vec;
      vaddr        <= next_vaddr;
      spc          <= next_spc;
      sbyte        <= next_sbyte;
      sipl3        <= next_sipl3;
    end
  end

  assign cpu_priority_level_o   = cpl;
  assign entry_o                = entry;
  assign vector_num_o           = vec;
  assign vector_addr_o          = vaddr;
  assign stack_pc_o             = spc;
  assign status_low_byte_o      = sbyte;
  assign stack_top_bit_o        = sipl3;
  assign hold_exec_o            = hold;
  assign reset_req_o            = rst_req;
  assign reset_cause_register_o = rcause;

  // ---------------------------------------------------------------
  // Shadow context
  // ---------------------------------------------------------------
  shadow_store i_shadow_store (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .push_i    (shadow_push_i),
    .pop_i     (shadow_pop_i),
    .save_i    (shadow_save_i),
    .restore_o (shadow_restore_o),
    .full_o    (shadow_full_o),
    .overrun_o (shadow_overrun_o)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_conflict; conflict |=> reset_req_o && reset_cause_register_o[15]; endproperty
  a_conflict: assert property (p_conflict) else $error("conflict did not reset");
  property p_trap_top; entry_o && vector_num_o < 6'h08 |-> cpu_priority_level_o[3]; endproperty
  a_trap_top: assert property (p_trap_top) else $error("trap entry without top bit");
  property p_irq_top; entry_o && vector_num_o >= 6'h08 |-> !cpu_priority_level_o[3]; endproperty
  a_irq_top: assert property (p_irq_top) else $error("interrupt entry with top bit");
  property p_strict;
    entry_o && vector_num_o >= 6'h08 |-> cpu_priority_level_o > $past(cpu_priority_level_o);
  endproperty
  a_strict: assert property (p_strict) else $error("interrupt not above level");
  property p_hard_hold;
    entry_o && vector_num_o inside {[6'h04:6'h06]} |-> hold_exec_o;
  endproperty
  a_hard_hold: assert property (p_hard_hold) else $error("hard trap did not hold");
  property p_flush; illegal_held && flush_i && !illegal_fetch_i |=> ##1 !reset_cause_register_o[2]
    || $past(reset_cause_register_o[2], 2); endproperty
  a_flush: assert property (p_flush) else $error("flushed opcode raised reset");
  property p_stack_low;
    sp_load_i && sp_value_i < 16'h0800 |=> pend[2] || reset_req_o || entry_o;
  endproperty
  a_stack_low: assert property (p_stack_low) else $error("stack underflow missed");
  property p_return;
    return_from_interrupt_op_i && state == exc_pkg::ST_RUN && !fatal |=>
      cpu_priority_level_o == {$past(popped_top_bit_i), $past(popped_status_byte_i[7:5])};
  endproperty
  a_return: assert property (p_return) else $error("return did not restore level");
  property p_nest;
    nesting_disable_bit_i && in_service != 4'h0 |=> !(entry_o && vector_num_o >= 6'h08);
  endproperty
  a_nest: assert property (p_nest) else $error("nested entry while disabled");
  property p_alt;
    entry_o && $past(alternate_table_select_i) |-> vector_addr_o >= 24'h000084;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate table not used");

  c_irq: cover property (entry_o && vector_num_o >= 6'h08);
  c_trap: cover property (entry_o && vector_num_o < 6'h08);
  c_conflict: cover property (conflict);
  c_return: cover property (return_from_interrupt_op_i && in_service != 4'h0);

endmodule
